// ==== rtl/bipolar_line_violation_detector.sv ====
// Behaviour
// - A mark with the same polarity as a mark directly before it decodes as zero and is not a violation.
// - A same-polarity mark with at least one zero after the previous mark is a violation and is counted.
// - In B8ZS mode a violation directly after a recognised eight-bit substitution is not counted.
// - In HDB3 mode both four-bit substitutions are removed and a wrong choice between them is never counted.
// - On framed all ones only a violation after a zero framing bit is reported, as the consecutive-mark rule gives.
// - The line code is HDB3 or AMI for E1 and B8ZS or AMI for T1/J1, chosen by configuration.
// - Counted violations are held in a 16 bit counter that is latched and restarted each second.
`timescale 1ns/10ps
`include "blv_defs.svh"
module bipolar_line_violation_detector (
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic E1_MODE_IN,
   input wire logic ZERO_SUBST_IN,
   input wire logic RX_VALID_IN,
   input wire logic RX_POS_IN,
   input wire logic RX_NEG_IN,
   output logic RX_READY_OUT,
   output logic DATA_OUT,
   output logic DATA_VALID_OUT,
   input wire logic DATA_READY_IN,
   output logic BPV_PULSE_OUT,
   input wire logic SECOND_LATCH_IN,
   output logic [`BLV_CNT_W-1:0] VIOL_COUNT_OUT,
   output logic [`BLV_CNT_W-1:0] VIOL_LATCHED_OUT,
   output blv_pkg::line_code_t LINE_CODE_OUT
);
   import blv_pkg::*;

   typedef struct packed {
      slot_t [`BLV_WIN_LAST:0] win;
      logic seen_mark;
      logic last_neg;
      logic prev_mark;
      logic skip_next;
      logic bpv_pulse;
      logic [`BLV_CNT_W-1:0] count;
      logic [`BLV_CNT_W-1:0] latched;
      line_code_t code;
   } det_state_t;

   det_state_t s_reg;
   det_state_t s_next;
   slot_t cur;
   slot_t oldest;
   logic accept;
   logic same_pol;
   logic b8_hit;
   logic h3_hit;
   logic count_ev;
   logic fifo_ready;

   function automatic line_code_t code_of(input logic e1, input logic subst);
      if (!subst) begin
         return CODE_AMI;
      end
      return e1 ? CODE_HDB3 : CODE_B8ZS;
   endfunction

   function automatic logic [`BLV_CNT_W-1:0] sat_inc(input logic [`BLV_CNT_W-1:0] v);
      return (v == `BLV_CNT_MAX) ? v : v + `BLV_CNT_ONE;
   endfunction

   function automatic logic is_zero(input slot_t e);
      return e.vld && !e.mark;
   endfunction

   // Upstream clock recovery runs on this clock, so the marks need no synchroniser
   assign accept = RX_VALID_IN && fifo_ready;
   assign oldest = s_reg.win[`BLV_WIN_LAST];
   assign same_pol = s_reg.seen_mark && (RX_NEG_IN == s_reg.last_neg);

   always_comb begin
      cur = '0;
      cur.vld = 1'b1;
      // Both rails at once carry no polarity, so it is taken as a space
      cur.mark = RX_POS_IN ^ RX_NEG_IN;
      cur.neg = RX_NEG_IN;
      if (cur.mark) begin
         if (same_pol && s_reg.prev_mark) begin
            cur.data = 1'b0;
            cur.bpv = 1'b0;
         end else begin
            cur.data = 1'b1;
            cur.bpv = same_pol && !(s_reg.skip_next && s_reg.code == CODE_B8ZS);
         end
      end
   end

   // 000VB0VB ends on the incoming bit; both V marks were flagged on arrival
   assign b8_hit = (s_reg.code == CODE_B8ZS) && cur.mark && !cur.bpv
      && s_reg.win[`BLV_B8_V2].mark && s_reg.win[`BLV_B8_V2].bpv
      && (s_reg.win[`BLV_B8_V2].neg != cur.neg)
      && is_zero(s_reg.win[`BLV_B8_Z1])
      && s_reg.win[`BLV_B8_B1].mark && (s_reg.win[`BLV_B8_B1].neg == s_reg.win[`BLV_B8_V2].neg)
      && s_reg.win[`BLV_B8_V1].mark && s_reg.win[`BLV_B8_V1].bpv && (s_reg.win[`BLV_B8_V1].neg == cur.neg)
      && is_zero(s_reg.win[`BLV_B8_Z2]) && is_zero(s_reg.win[`BLV_B8_Z3]) && is_zero(s_reg.win[`BLV_B8_Z4]);

   // 000V or B00V; whether B was due is not checked, so a wrong choice goes uncounted
   assign h3_hit = (s_reg.code == CODE_HDB3) && cur.bpv
      && is_zero(s_reg.win[`BLV_H3_Z1]) && is_zero(s_reg.win[`BLV_H3_Z2])
      && (is_zero(s_reg.win[`BLV_H3_B])
         || (s_reg.win[`BLV_H3_B].mark && s_reg.win[`BLV_H3_B].neg == cur.neg));

   assign count_ev = accept && oldest.vld && oldest.bpv;

   always_comb begin
      s_next = s_reg;
      s_next.code = code_of(E1_MODE_IN, ZERO_SUBST_IN);
      s_next.bpv_pulse = count_ev;
      if (accept) begin
         for (int i = `BLV_WIN_LAST; i > 0; i--) begin
            s_next.win[i] = s_reg.win[i-1];
         end
         s_next.win[0] = cur;
         if (b8_hit) begin
            s_next.win[0].data = 1'b0;
            s_next.win[`BLV_B8_V2+1].data = 1'b0;
            s_next.win[`BLV_B8_V2+1].bpv = 1'b0;
            s_next.win[`BLV_B8_B1+1].data = 1'b0;
            s_next.win[`BLV_B8_V1+1].data = 1'b0;
            s_next.win[`BLV_B8_V1+1].bpv = 1'b0;
         end
         if (h3_hit) begin
            s_next.win[0].data = 1'b0;
            s_next.win[0].bpv = 1'b0;
            s_next.win[`BLV_H3_B+1].data = 1'b0;
         end
         if (cur.mark) begin
            s_next.skip_next = b8_hit;
            s_next.seen_mark = 1'b1;
            s_next.last_neg = cur.neg;
         end
         s_next.prev_mark = cur.mark;
      end
      // A violation in the latch cycle starts the new second
      if (SECOND_LATCH_IN) begin
         s_next.latched = s_reg.count;
         s_next.count = count_ev ? `BLV_CNT_ONE : `BLV_CNT_ZERO;
      end else if (count_ev) begin
         s_next.count = sat_inc(s_reg.count);
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Back-pressure: when the buffer fills the line side sees ready drop
   blv_fifo #(
      .WIDTH(`BLV_FIFO_WIDTH),
      .DEPTH(`BLV_FIFO_DEPTH)
   ) u_fifo (
      .clk_in(REF_CLK_IN),
      .rst_in(RST_IN),
      .in_valid_in(accept && oldest.vld),
      .in_data_in(oldest.data),
      .in_ready_out(fifo_ready),
      .out_valid_out(DATA_VALID_OUT),
      .out_data_out(DATA_OUT),
      .out_ready_in(DATA_READY_IN)
   );

   assign RX_READY_OUT = fifo_ready;
   assign BPV_PULSE_OUT = s_reg.bpv_pulse;
   assign VIOL_COUNT_OUT = s_reg.count;
   assign VIOL_LATCHED_OUT = s_reg.latched;
   assign LINE_CODE_OUT = s_reg.code;

   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);

   sequence adjacent_repeat_s;
      accept && cur.mark && same_pol && s_reg.prev_mark;
   endsequence

   sequence spaced_repeat_s;
      accept && cur.mark && same_pol && !s_reg.prev_mark && s_reg.code == CODE_AMI;
   endsequence

   sequence counted_exit_s;
      count_ev && !SECOND_LATCH_IN && s_reg.count != `BLV_CNT_MAX;
   endsequence

   adjacent_mask_a: assert property (adjacent_repeat_s |=> !s_reg.win[0].data && !s_reg.win[0].bpv)
      else $error("adjacent repeat mark not masked");
   adjacent_nocount_a: assert property (adjacent_repeat_s |-> !cur.bpv && !cur.data)
      else $error("adjacent repeat mark decoded as violation");
   spaced_flag_a: assert property (spaced_repeat_s |=> s_reg.win[0].bpv && s_reg.win[0].data)
      else $error("spaced violation not flagged");
   count_step_a: assert property (counted_exit_s |=> s_reg.count == $past(s_reg.count) + `BLV_CNT_ONE)
      else $error("violation count did not step");
   count_pulse_a: assert property (counted_exit_s |=> BPV_PULSE_OUT)
      else $error("violation pulse missing");
   count_hold_a: assert property (!count_ev && !SECOND_LATCH_IN |=> $stable(s_reg.count))
      else $error("count moved without violation");
   latch_copy_a: assert property (SECOND_LATCH_IN |=> s_reg.latched == $past(s_reg.count))
      else $error("second latch lost the count");
   b8_clear_a: assert property (accept && b8_hit |=> !s_reg.win[1].bpv && !s_reg.win[4].bpv && s_reg.skip_next)
      else $error("substitution violation left flagged");
   b8_skip_a: assert property (s_reg.skip_next && s_reg.code == CODE_B8ZS && accept && cur.mark
      |=> !s_reg.win[0].bpv)
      else $error("violation after substitution flagged");
   h3_clear_a: assert property (accept && h3_hit |=> !s_reg.win[0].bpv && !s_reg.win[0].data)
      else $error("hdb3 substitution flagged");
   code_sel_a: assert property (E1_MODE_IN && !ZERO_SUBST_IN |=> LINE_CODE_OUT == CODE_AMI)
      else $error("line code selection wrong");
   code_hdb3_a: assert property (E1_MODE_IN && ZERO_SUBST_IN |=> LINE_CODE_OUT == CODE_HDB3)
      else $error("hdb3 code not selected");
   code_b8zs_a: assert property (!E1_MODE_IN && ZERO_SUBST_IN |=> LINE_CODE_OUT == CODE_B8ZS)
      else $error("b8zs code not selected");
   // A violation leaving in the latch cycle must open the new second with one
   latch_restart_a: assert property (SECOND_LATCH_IN
      |=> s_reg.count == ($past(count_ev) ? `BLV_CNT_ONE : `BLV_CNT_ZERO))
      else $error("count not restarted at second latch");
   pulse_only_a: assert property (!count_ev |=> !BPV_PULSE_OUT)
      else $error("violation pulse without counted violation");
endmodule

// ==== rtl/blv_defs.svh ====
`ifndef BLV_DEFS_SVH
`define BLV_DEFS_SVH

// Decode window: one B8ZS substitution pattern plus the bit that completes it
`define BLV_WIN_DEPTH 8
`define BLV_WIN_LAST 7
`define BLV_CNT_W 16
`define BLV_CNT_ZERO 16'h0000
`define BLV_CNT_ONE 16'h0001
`define BLV_CNT_MAX 16'hFFFF
`define BLV_FIFO_WIDTH 1
`define BLV_FIFO_DEPTH 4

// Window positions, newest first, of the marks and zeros of a substitution pattern
`define BLV_B8_V2 0
`define BLV_B8_Z1 1
`define BLV_B8_B1 2
`define BLV_B8_V1 3
`define BLV_B8_Z2 4
`define BLV_B8_Z3 5
`define BLV_B8_Z4 6
`define BLV_H3_Z1 0
`define BLV_H3_Z2 1
`define BLV_H3_B 2

`endif

// ==== rtl/blv_fifo.sv ====
`timescale 1ns/10ps
`include "blv_defs.svh"
module blv_fifo #(
   parameter int WIDTH = `BLV_FIFO_WIDTH,
   parameter int DEPTH = `BLV_FIFO_DEPTH
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [CW-1:0] ONE_CNT = CW'(1);

   // Shift structure: slot 0 is always the head, so read data is a register
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] dat;
      logic [CW-1:0] count;
      logic head_vld;
      logic rdy;
   } fifo_state_t;

   fifo_state_t s_reg;
   fifo_state_t s_next;
   logic push;
   logic pop;
   logic [CW-1:0] base;

   assign push = in_valid_in && s_reg.rdy;
   assign pop = out_ready_in && s_reg.head_vld;

   always_comb begin
      s_next = s_reg;
      base = s_reg.count;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            s_next.dat[i] = s_reg.dat[i+1];
         end
         base = s_reg.count - ONE_CNT;
      end
      if (push) begin
         s_next.dat[base] = in_data_in;
      end
      s_next.count = push ? base + ONE_CNT : base;
      s_next.head_vld = (s_next.count != '0);
      s_next.rdy = (s_next.count != FULL_CNT);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_reg <= '0;
         s_reg.rdy <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign in_ready_out = s_reg.rdy;
   assign out_valid_out = s_reg.head_vld;
   assign out_data_out = s_reg.dat[0];

   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   fill_bound_a: assert property (s_reg.count <= FULL_CNT)
      else $error("fifo count beyond depth");
   full_stall_a: assert property ((s_reg.count == FULL_CNT) |-> !in_ready_out)
      else $error("fifo ready while full");
   push_only_a: assert property (push && !pop |=> s_reg.count == $past(s_reg.count) + ONE_CNT)
      else $error("fifo push lost");
endmodule

// ==== rtl/blv_pkg.sv ====
package blv_pkg;
   typedef enum logic [1:0] {
      CODE_AMI,
      CODE_HDB3,
      CODE_B8ZS
   } line_code_t;

   // One received bit on its way through the decode window
   typedef struct packed {
      logic vld;
      logic mark;
      logic neg;
      logic data;
      logic bpv;
   } slot_t;
endpackage

// ==== test/line_tx_model.sv ====
`timescale 1ns/10ps
module line_tx_model (
   input wire logic clk_in,
   input wire logic ready_in,
   output logic valid_out,
   output logic pos_out,
   output logic neg_out
);
   logic last_pos = 1'b0;
   initial begin
      valid_out = 1'b0;
      pos_out = 1'b1;
      neg_out = 1'b0;
   end
   // Kind 0 space, 1 alternating mark, 2 mark repeating the last polarity
   task automatic send(input logic [1:0] kind);
      logic p;
      p = (kind == 2'h2) ? last_pos : !last_pos;
      if (kind != 2'h0) last_pos = p;
      valid_out <= 1'b1;
      pos_out <= (kind != 2'h0) && p;
      neg_out <= (kind != 2'h0) && !p;
      do @(posedge clk_in); while (ready_in !== 1'b1);
   endtask
   // Rails flip when released so a stale level never looks like a held bit
   task automatic idle;
      valid_out <= 1'b0;
      pos_out <= !pos_out;
      neg_out <= !neg_out;
   endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
   import blv_pkg::*;
   logic clk, rst, e1_mode, zero_subst, data_ready, sec_latch, stall;
   logic rx_valid, rx_pos, rx_neg, rx_ready, data, data_valid, bpv_pulse;
   logic [15:0] viol_count, viol_latched, n_pulse, exp_cnt;
   line_code_t line_code;
   logic exp_q[$];
   int n_fail, checks_done;

   bipolar_line_violation_detector u_dut (
      .REF_CLK_IN(clk), .RST_IN(rst), .E1_MODE_IN(e1_mode), .ZERO_SUBST_IN(zero_subst),
      .RX_VALID_IN(rx_valid), .RX_POS_IN(rx_pos), .RX_NEG_IN(rx_neg), .RX_READY_OUT(rx_ready),
      .DATA_OUT(data), .DATA_VALID_OUT(data_valid), .DATA_READY_IN(data_ready),
      .BPV_PULSE_OUT(bpv_pulse), .SECOND_LATCH_IN(sec_latch), .VIOL_COUNT_OUT(viol_count),
      .VIOL_LATCHED_OUT(viol_latched), .LINE_CODE_OUT(line_code));
   line_tx_model u_line (.clk_in(clk), .ready_in(rx_ready), .valid_out(rx_valid), .pos_out(rx_pos),
      .neg_out(rx_neg));

   task automatic fail(input string msg);
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) fail("bit value");
   endtask
   task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) fail("violation count");
   endtask
   task automatic chk_code(input line_code_t got, input line_code_t exp);
      checks_done++;
      if (got !== exp) fail("line code");
   endtask
   task automatic results;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic seq(input string s, input string d);
      for (int i = 0; i < s.len(); i++) begin
         exp_q.push_back(d[i] == 8'h31);
         u_line.send(2'(s[i] - 8'h30));
      end
   endtask
   // Eight spaces push every earlier bit out of the decode window
   task automatic settle;
      seq("00000000", "00000000");
      u_line.idle();
      repeat (3) @(posedge clk);
      chk_cnt(viol_count, exp_cnt);
      chk_cnt(n_pulse, exp_cnt);
   endtask
   task automatic mode(input logic e1, input logic zs, input line_code_t code);
      e1_mode <= e1;
      zero_subst <= zs;
      repeat (3) @(posedge clk);
      chk_code(line_code, code);
   endtask
   task automatic drain;
      for (int i = 0; i < 200 && exp_q.size() > 8; i++) @(posedge clk);
      if (exp_q.size() > 8) fail("output buffer did not drain");
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = !clk;
   end
   always @(posedge clk) begin
      if (rst === 1'b1) begin
         data_ready <= 1'b0;
         n_pulse <= 16'h0000;
      end else begin
         data_ready <= !stall && ($urandom % 4 != 0);
         if (bpv_pulse === 1'b1) n_pulse <= n_pulse + 16'h0001;
      end
      if (data_valid === 1'b1 && data_ready === 1'b1) begin
         if (exp_q.size() == 0) fail("unexpected bit");
         else chk_bit(data, exp_q.pop_front());
      end
   end
   initial begin
      #1_000_000;
      fail("timeout");
      results();
   end
   initial begin
      logic k;
      void'($urandom(32'h0000_634d));
      rst = 1'b1;
      e1_mode = 1'b0;
      zero_subst = 1'b0;
      sec_latch = 1'b0;
      stall = 1'b0;
      exp_cnt = 16'h0000;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      mode(1'b0, 1'b0, CODE_AMI);
      for (int i = 0; i < 32; i++) begin
         k = 1'($urandom % 2);
         exp_q.push_back(k);
         u_line.send({1'b0, k});
      end
      seq("12", "10");
      seq("102", "101");
      seq("1110211", "1110111");
      seq("10002", "10001");
      exp_cnt = exp_cnt + 16'h0003;
      settle();
      mode(1'b0, 1'b1, CODE_B8ZS);
      seq("1000210210202", "1000000000101");
      exp_cnt = exp_cnt + 16'h0001;
      settle();
      mode(1'b1, 1'b1, CODE_HDB3);
      seq("10002100020100201002", "10000100000000000000");
      settle();
      mode(1'b1, 1'b0, CODE_AMI);
      seq("1002", "1001");
      exp_cnt = exp_cnt + 16'h0001;
      settle();
      // Stalled sink: four more bits fill the output buffer and the line must be held off
      drain();
      stall <= 1'b1;
      seq("1010", "1010");
      u_line.idle();
      repeat (3) @(posedge clk);
      chk_bit(rx_ready, 1'b0);
      stall <= 1'b0;
      seq("0101", "0101");
      settle();
      drain();
      sec_latch <= 1'b1;
      @(posedge clk);
      sec_latch <= 1'b0;
      repeat (2) @(posedge clk);
      chk_cnt(viol_latched, exp_cnt);
      chk_cnt(viol_count, 16'h0000);
      results();
   end
endmodule
